// [debug_serial_port_pkg.sv]
package debug_serial_port_pkg;

    // ==========================================================
    // Link framing
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam logic [3:0] LAST_DATA_IDX = 4'h7;
    localparam logic [3:0] SEP_IDX = 4'h8;
    localparam logic [2:0] MSB_IDX = 3'h7;

    // ==========================================================
    // Debug register space
    localparam logic [6:0] WR_TOP = 7'h30;
    localparam logic [6:0] RD_TOP = 7'h20;
    localparam logic [6:0] BUS_REG_ADDR = 7'h17;
    localparam int ALLOW_BIT = 0;
    localparam logic [6:0] ADDR_STEP = 7'h01;

    // ==========================================================
    // Software register map, byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    // ==========================================================
    // Types
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] wdata;
    } dreg_cmd_t;

    typedef struct packed {
        logic req;
        logic busy;
        logic grant;
    } grant_stat_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_HDR = 4'b0010,
        S_WR = 4'b0100,
        S_RD = 4'b1000
    } link_state_t;

endpackage

// [link_sync.sv]
module link_sync #(
    parameter int W = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    initial
    begin
        if (W < 1)
        begin
            $error("link_sync needs at least one bit");
        end
    end

    // ==========================================================
    // Two stages; idle lines rest high, so reset to ones
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_r <= '1;
            sync_r <= '1;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

// [grant_regs_ahb.sv]
module grant_regs_ahb (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_allow,
    input wire debug_serial_port_pkg::grant_stat_t i_stat,
    output logic o_allow_we,
    output logic o_allow_val
);

    logic take;
    logic [7:0] ofs;
    logic [31:0] rd_word;
    logic wr_pend_r;
    logic [7:0] wr_ofs_r;
    logic [31:0] hrdata_r;
    logic ready_r;

    // ==========================================================
    // Address phase decode; zero wait states, always OKAY
    assign take = i_hsel && i_hready &&
        (i_htrans == debug_serial_port_pkg::HTRANS_NONSEQ ||
         i_htrans == debug_serial_port_pkg::HTRANS_SEQ);
    assign ofs = i_haddr[7:0];
    assign rd_word =
        (ofs == debug_serial_port_pkg::OFS_CTRL) ? {31'h0000_0000, i_allow} :
        (ofs == debug_serial_port_pkg::OFS_STAT) ? {29'h0000_0000, i_stat} :
        32'h0000_0000;

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            ready_r <= 1'b1;
        end
        else
        begin
            wr_pend_r <= take && i_hwrite;
            wr_ofs_r <= ofs;
            hrdata_r <= (take && !i_hwrite) ? rd_word : 32'h0000_0000;
            ready_r <= 1'b1;
        end
    end

    // ==========================================================
    // Data phase write; unmapped offsets are ignored
    assign o_allow_we = wr_pend_r &&
        (wr_ofs_r == debug_serial_port_pkg::OFS_CTRL);
    assign o_allow_val = i_hwdata[debug_serial_port_pkg::ALLOW_BIT];
    assign o_hreadyout = ready_r;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_r;

endmodule

// [debug_serial_port.sv]
// Operation
// [RULE1] Separator bit follows every byte
// [RULE2] Probe holds separator low when grants enabled
// [RULE3] Register address follows start condition
// [RULE4] Header: 7-bit address, direction, separator
// [RULE5] Separate read and write maps
// [RULE6] No new start repeats the operation
// [RULE7] Write data captured on next 8 rises
// [RULE8] Write address increments, stops at 30h
// [RULE9] Read data loaded after separator, MSB first
// [RULE10] Read address increments, stops at 20h
// [RULE11] Probe adjusts program counter between reads
// [RULE12] Break halts CPU only, clocks run
// [RULE13] Peripheral accesses keep normal side effects
// [RULE14] Grant enable off after reset
// [RULE15] Grant waits for current operation end
// [RULE16] Separator low withholds grant, high allows
// [RULE17] Grant state readable and on pin
// [RULE18] Probe avoids memory while bus granted
// [RULE19] Granted accesses take external wait states
// [RULE20] Probe stays in debug while granted
// [RULE21] Start is data fall with clock high
// [RULE22] Probe changes data only clock low
// [RULE23] Nine clocks per byte
// [RULE24] Sample on rise, drive on fall
// [RULE25] Synchronise link inputs before decoding
module debug_serial_port (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_debug_link_clock,
    input wire logic i_debug_link_data,
    output logic o_debug_link_data,
    output logic o_debug_link_data_oe,
    input wire logic i_debug_mode,
    input wire logic i_ext_bus_request_n,
    output logic o_ext_bus_grant_n,
    output logic o_dreg_req,
    output debug_serial_port_pkg::dreg_cmd_t o_dreg_cmd,
    input wire logic i_dreg_ack,
    input wire logic [7:0] i_dreg_rdata,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata
);

    // ==========================================================
    // Link synchroniser
    logic [2:0] sync_out;
    logic scl_s;
    logic sda_s;
    logic breq_s;
    logic scl_q_r;
    logic sda_q_r;
    logic rise;
    logic fall;
    logic start;

    link_sync #(.W(3)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_async({i_ext_bus_request_n, i_debug_link_data,
            i_debug_link_clock}),
        .o_sync(sync_out)
    ); // [RULE25]

    assign scl_s = sync_out[0];
    assign sda_s = sync_out[1];
    assign breq_s = ~sync_out[2];
    assign rise = scl_s && !scl_q_r; // [RULE24]
    assign fall = !scl_s && scl_q_r; // [RULE24]
    // A rising data edge with clock high matches nothing here
    assign start = scl_s && scl_q_r && sda_q_r && !sda_s; // [RULE21]

    // ==========================================================
    // State
    debug_serial_port_pkg::link_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shin_r, shin_nxt;
    logic [7:0] shout_r, shout_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic busy_r, busy_nxt;
    logic oe_r, oe_nxt;
    logic dout_r, dout_nxt;
    logic req_r, req_nxt;
    debug_serial_port_pkg::dreg_cmd_t cmd_r, cmd_nxt;
    logic allow_r, allow_nxt;
    logic grant_n_r, grant_n_nxt;
    logic grant;
    logic ahb_allow_we;
    logic ahb_allow_val;
    debug_serial_port_pkg::grant_stat_t stat;
    logic [7:0] stat_byte;
    logic [7:0] byte_in;
    logic [6:0] rd_addr;

    function automatic logic [6:0] step_addr(input logic [6:0] a,
                                             input logic [6:0] top);
        step_addr = (a == top) ? a : a + debug_serial_port_pkg::ADDR_STEP;
    endfunction

    function automatic logic is_local(input logic [6:0] a);
        is_local = (a == debug_serial_port_pkg::BUS_REG_ADDR);
    endfunction

    assign grant = !grant_n_r;
    assign stat = '{req: breq_s, busy: busy_r, grant: grant};
    assign stat_byte = {5'h00, stat}; // [RULE17]
    assign byte_in = {shin_r[6:0], sda_s};
    assign rd_addr = (state_r == debug_serial_port_pkg::S_HDR) ?
        shin_r[7:1] : step_addr(addr_r, debug_serial_port_pkg::RD_TOP);

    // ==========================================================
    // Protocol next state
    always_comb
    begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shin_nxt = shin_r;
        shout_nxt = shout_r;
        addr_nxt = addr_r;
        busy_nxt = busy_r;
        oe_nxt = oe_r;
        dout_nxt = dout_r;
        req_nxt = req_r;
        cmd_nxt = cmd_r;
        allow_nxt = ahb_allow_we ? ahb_allow_val : allow_r;
        // Access held until the system answers, so wait states apply
        if (req_r && i_dreg_ack) // [RULE19]
        begin
            req_nxt = 1'b0;
            if (!cmd_r.we)
            begin
                shout_nxt = i_dreg_rdata; // [RULE9]
            end
        end
        if (start)
        begin
            state_nxt = debug_serial_port_pkg::S_HDR; // [RULE3]
            bit_cnt_nxt = 4'h0;
            busy_nxt = 1'b1;
            oe_nxt = 1'b0;
        end
        else if (rise && state_r != debug_serial_port_pkg::S_IDLE)
        begin
            if (bit_cnt_r == debug_serial_port_pkg::SEP_IDX) // [RULE1]
            begin
                bit_cnt_nxt = 4'h0; // [RULE23]
                busy_nxt = !sda_s; // [RULE16]
                if (state_r == debug_serial_port_pkg::S_HDR)
                begin
                    addr_nxt = shin_r[7:1];
                    state_nxt = shin_r[0] ? debug_serial_port_pkg::S_RD :
                        debug_serial_port_pkg::S_WR; // [RULE4]
                end
                else if (state_r == debug_serial_port_pkg::S_RD)
                begin
                    addr_nxt = rd_addr; // [RULE10]
                end
                // Read map: bus status local, the rest from the system
                if (state_r == debug_serial_port_pkg::S_RD ||
                    (state_r == debug_serial_port_pkg::S_HDR && shin_r[0]))
                begin
                    if (is_local(rd_addr)) // [RULE5]
                    begin
                        shout_nxt = stat_byte; // [RULE17]
                    end
                    else
                    begin
                        req_nxt = 1'b1; // [RULE6]
                        cmd_nxt = '{we: 1'b0, addr: rd_addr, wdata: 8'h00};
                    end
                end
            end
            else
            begin
                shin_nxt = byte_in;
                bit_cnt_nxt = bit_cnt_r + 4'h1;
                if (state_r == debug_serial_port_pkg::S_WR &&
                    bit_cnt_r == debug_serial_port_pkg::LAST_DATA_IDX) // [RULE7]
                begin
                    // Write map: bus control local, the rest forwarded
                    if (is_local(addr_r)) // [RULE5]
                    begin
                        allow_nxt = byte_in[debug_serial_port_pkg::ALLOW_BIT];
                    end
                    else
                    begin
                        // Plain system access, same side effects as CPU
                        req_nxt = 1'b1; // [RULE13]
                        cmd_nxt = '{we: 1'b1, addr: addr_r, wdata: byte_in};
                    end
                    addr_nxt = step_addr(addr_r,
                        debug_serial_port_pkg::WR_TOP); // [RULE8]
                end
            end
        end
        else if (fall && state_r == debug_serial_port_pkg::S_RD)
        begin
            if (bit_cnt_r == debug_serial_port_pkg::SEP_IDX)
            begin
                oe_nxt = 1'b0;
            end
            else
            begin
                oe_nxt = 1'b1;
                dout_nxt = shout_r[debug_serial_port_pkg::MSB_IDX -
                    bit_cnt_r[2:0]]; // [RULE24]
            end
        end
    end

    // ==========================================================
    // Bus grant; once given it holds until the request drops
    always_comb
    begin
        if (grant)
        begin
            grant_n_nxt = !breq_s;
        end
        else
        begin
            grant_n_nxt = !(breq_s && allow_r && i_debug_mode &&
                !busy_r); // [RULE15]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= debug_serial_port_pkg::S_IDLE;
            bit_cnt_r <= 4'h0;
            shin_r <= 8'h00;
            shout_r <= 8'h00;
            addr_r <= 7'h00;
            busy_r <= 1'b0;
            oe_r <= 1'b0;
            dout_r <= 1'b0;
            req_r <= 1'b0;
            cmd_r <= '0;
            allow_r <= 1'b0; // [RULE14]
            grant_n_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shin_r <= shin_nxt;
            shout_r <= shout_nxt;
            addr_r <= addr_nxt;
            busy_r <= busy_nxt;
            oe_r <= oe_nxt;
            dout_r <= dout_nxt;
            req_r <= req_nxt;
            cmd_r <= cmd_nxt;
            allow_r <= allow_nxt;
            grant_n_r <= grant_n_nxt;
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // ==========================================================
    // Outputs; the CPU clock is never gated from here
    assign o_debug_link_data = dout_r;
    assign o_debug_link_data_oe = oe_r;
    assign o_ext_bus_grant_n = grant_n_r; // [RULE17]
    assign o_dreg_req = req_r; // [RULE12]
    assign o_dreg_cmd = cmd_r;

    grant_regs_ahb u_regs (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hsize(i_hsize),
        .i_hwdata(i_hwdata),
        .i_hready(i_hready),
        .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp),
        .o_hrdata(o_hrdata),
        .i_allow(allow_r),
        .i_stat(stat),
        .o_allow_we(ahb_allow_we),
        .o_allow_val(ahb_allow_val)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    a_start_drops_drive: assert property ( // [RULE21]
        start |=> !o_debug_link_data_oe && state_r ==
            debug_serial_port_pkg::S_HDR)
        else $error("start did not enter header");

    a_idle_rise_ignored: assert property ( // [RULE21]
        (state_r == debug_serial_port_pkg::S_IDLE && !start)
            |=> state_r == debug_serial_port_pkg::S_IDLE)
        else $error("left idle without start");

    a_drive_only_read: assert property ( // [RULE9]
        o_debug_link_data_oe |-> state_r == debug_serial_port_pkg::S_RD)
        else $error("data driven outside read");

    a_data_on_fall: assert property ( // [RULE24]
        $changed(o_debug_link_data) |-> $past(fall))
        else $error("read data changed off a falling edge");

    a_wr_addr_step: assert property ( // [RULE8]
        (rise && !start && state_r == debug_serial_port_pkg::S_WR &&
         bit_cnt_r == debug_serial_port_pkg::LAST_DATA_IDX &&
         addr_r != debug_serial_port_pkg::WR_TOP)
            |=> addr_r == $past(addr_r) + debug_serial_port_pkg::ADDR_STEP)
        else $error("write address did not step");

    a_wr_addr_stop: assert property ( // [RULE8]
        (state_r == debug_serial_port_pkg::S_WR &&
         addr_r == debug_serial_port_pkg::WR_TOP && !start)
            |=> addr_r == debug_serial_port_pkg::WR_TOP)
        else $error("write address passed top");

    a_rd_addr_stop: assert property ( // [RULE10]
        (state_r == debug_serial_port_pkg::S_RD &&
         addr_r == debug_serial_port_pkg::RD_TOP && !start)
            |=> addr_r == debug_serial_port_pkg::RD_TOP)
        else $error("read address passed top");

    a_sep_sets_busy: assert property ( // [RULE16]
        (rise && !start && state_r != debug_serial_port_pkg::S_IDLE &&
         bit_cnt_r == debug_serial_port_pkg::SEP_IDX)
            |=> busy_r == !$past(sda_s) && bit_cnt_r == 4'h0)
        else $error("separator not reflected in busy");

    a_grant_when_free: assert property ( // [RULE15]
        $fell(o_ext_bus_grant_n) |-> $past(!busy_r && allow_r && breq_s))
        else $error("grant given while busy or disabled");

    a_no_grant_disabled: assert property ( // [RULE14]
        (!allow_r && o_ext_bus_grant_n) |=> o_ext_bus_grant_n)
        else $error("grant without enable");

    a_bit_count_range: assert property ( // [RULE23]
        bit_cnt_r <= debug_serial_port_pkg::SEP_IDX)
        else $error("bit counter out of range");

    a_write_issued: assert property ( // [RULE7]
        (rise && !start && state_r == debug_serial_port_pkg::S_WR &&
         bit_cnt_r == debug_serial_port_pkg::LAST_DATA_IDX &&
         !is_local(addr_r))
            |=> o_dreg_req && o_dreg_cmd.we &&
                o_dreg_cmd.addr == $past(addr_r))
        else $error("write byte not forwarded");

    a_read_loaded: assert property ( // [RULE9]
        (o_dreg_req && !o_dreg_cmd.we && i_dreg_ack && !rise)
            |=> shout_r == $past(i_dreg_rdata))
        else $error("read data not loaded");

endmodule

// [debug_probe_model.sv]
module debug_probe_model (
    output logic o_link_clock,
    output logic o_link_data,
    output logic o_link_oe,
    input wire logic i_link_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // ====
    // Link idles with clock high, stands still between frames
    initial
    begin
        o_link_clock = 1'b1;
        o_link_data = 1'b1;
        o_link_oe = 1'b1;
    end

    task automatic start_cond();
        #1.3;
        o_link_data = 1'b1;
        #80;
        o_link_data = 1'b0;
        #80;
    endtask

    // Data line rises with clock high: must not count as a start
    task automatic rise_no_start();
        o_link_clock = 1'b0;
        o_link_data = 1'b0;
        #80;
        o_link_clock = 1'b1;
        #80;
        o_link_data = 1'b1;
        #80;
    endtask

    task automatic bit_cycle(input logic v, input logic drv, output logic got);
        o_link_clock = 1'b0;
        #20;
        o_link_oe = drv;
        o_link_data = v;
        #60;
        o_link_clock = 1'b1;
        got = i_link_data;
        #80;
    endtask

    task automatic send_byte(input logic [7:0] b, input logic sep);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], 1'b1, g);
        bit_cycle(sep, 1'b1, g);
    endtask

    // Released line is left to the bench's changing float value
    task automatic recv_byte(output logic [7:0] b, input logic sep);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b0, 1'b0, b[i]);
        bit_cycle(sep, 1'b1, g);
    endtask
endmodule

// [tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys, reset_n, link_clock, probe_data, probe_oe, link_wire;
    logic dev_data, dev_oe, float_r, debug_mode, bus_req_n, grant_n;
    logic dreg_req, ack_r, hsel, hwrite, hready, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] rd_r, salt;
    int wait_r, bad_count, checks, cycles;
    debug_serial_port_pkg::dreg_cmd_t cmd;
    debug_serial_port_pkg::dreg_cmd_t seen_q[$];

    // Undriven line wanders so a stale bit never looks valid
    assign link_wire = dev_oe ? dev_data : (probe_oe ? probe_data : float_r);

    debug_serial_port dut_u (
        .i_clk_sys(clk_sys),
        .i_reset_n(reset_n),
        .i_debug_link_clock(link_clock),
        .i_debug_link_data(link_wire),
        .o_debug_link_data(dev_data),
        .o_debug_link_data_oe(dev_oe),
        .i_debug_mode(debug_mode),
        .i_ext_bus_request_n(bus_req_n),
        .o_ext_bus_grant_n(grant_n),
        .o_dreg_req(dreg_req),
        .o_dreg_cmd(cmd),
        .i_dreg_ack(ack_r),
        .i_dreg_rdata(rd_r),
        .i_hsel(hsel),
        .i_haddr(haddr),
        .i_htrans(htrans),
        .i_hwrite(hwrite),
        .i_hsize(hsize),
        .i_hwdata(hwdata),
        .i_hready(hready),
        .o_hreadyout(hready),
        .o_hresp(hresp),
        .o_hrdata(hrdata)
    );

    debug_probe_model probe_u (
        .o_link_clock(link_clock),
        .o_link_data(probe_data),
        .o_link_oe(probe_oe),
        .i_link_data(link_wire)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ====
    // Checking and closing
    task automatic complete_run();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] exp_rd(input logic [6:0] a);
        return {1'b0, a} ^ salt;
    endfunction

    function automatic logic [6:0] capped(input logic [6:0] a, input int i,
                                          input logic [6:0] top);
        int s;
        s = int'(a) + i;
        return (s > int'(top)) ? top : 7'(s);
    endfunction

    // Register side with random wait states and one-cycle ack
    always @(posedge clk_sys)
    begin
        float_r <= ~float_r;
        cycles <= cycles + 1;
        ack_r <= 1'b0;
        if (cycles == 40000)
        begin
            bad_count++;
            complete_run();
        end
        if (dreg_req && !ack_r)
        begin
            if (wait_r == 0)
            begin
                ack_r <= 1'b1;
                rd_r <= exp_rd(cmd.addr);
                seen_q.push_back(cmd);
                wait_r <= int'($urandom_range(3, 0));
            end
            else
                wait_r <= wait_r - 1;
        end
    end

    // ====
    // Bus and link tasks
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= debug_serial_port_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic link_write(input logic [6:0] a, input int n);
        logic [7:0] d[$];
        seen_q.delete();
        probe_u.start_cond();
        probe_u.send_byte({a, 1'b0}, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            d.push_back(8'($urandom));
            probe_u.send_byte(d[i], i == n - 1);
        end
        check("wr_count", seen_q.size(), n);
        for (int i = 0; i < n && i < seen_q.size(); i++)
            check("wr_cmd", seen_q[i],
                  {1'b1, capped(a, i, debug_serial_port_pkg::WR_TOP), d[i]});
    endtask

    task automatic link_read(input logic [6:0] a, input int n);
        logic [7:0] b;
        logic [6:0] ea;
        seen_q.delete();
        probe_u.start_cond();
        probe_u.send_byte({a, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            ea = capped(a, i, debug_serial_port_pkg::RD_TOP);
            probe_u.recv_byte(b, i == n - 1);
            check("rd_data", b, exp_rd(ea));
            check("rd_addr", {seen_q[i].we, seen_q[i].addr}, {1'b0, ea});
        end
    endtask

    // ====
    // Main sequence
    initial
    begin
        logic [31:0] r;
        void'($urandom(10502));
        salt = 8'($urandom);
        {reset_n, hsel, hwrite, debug_mode, ack_r, float_r} = 6'h00;
        {htrans, hsize, haddr, hwdata, rd_r} = 77'h0;
        bus_req_n = 1'b1;
        wait_r = 0;
        bad_count = 0;
        checks = 0;
        cycles = 0;
        repeat (6) @(posedge clk_sys);
        check("grant_rst", grant_n, 1'b1);
        check("oe_rst", dev_oe, 1'b0);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        probe_u.rise_no_start();
        probe_u.send_byte(8'h00, 1'b1);
        probe_u.send_byte(8'hA5, 1'b1);
        check("no_start", seen_q.size(), 0);
        ahb(1'b0, 32'(debug_serial_port_pkg::OFS_CTRL), 32'h0, r);
        check("ctrl_rst", r, 32'h0);
        ahb(1'b0, 32'h0000_0008, 32'h0, r);
        check("unmapped", r, 32'h0);
        link_write(7'h00, 1);
        link_read(7'h00, 1);
        link_write(7'h2E, 4);
        link_read(7'h1E, 4);
        repeat (4)
        begin
            link_write(7'($urandom_range(15, 0)), int'($urandom_range(3, 1)));
            // Each read restarts with a fresh header, no counter tricks
            link_read(7'($urandom_range(15, 0)), int'($urandom_range(3, 1)));
        end
        @(posedge clk_sys);
        // Debug mode stays on to the end, even while granted
        debug_mode <= 1'b1;
        bus_req_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        check("grant_off", grant_n, 1'b1);
        ahb(1'b1, 32'(debug_serial_port_pkg::OFS_CTRL), 32'h0000_0001, r);
        repeat (8) @(posedge clk_sys);
        check("grant_idle", grant_n, 1'b0);
        bus_req_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check("grant_drop", grant_n, 1'b1);
        probe_u.start_cond();
        probe_u.send_byte({7'h10, 1'b0}, 1'b0);
        @(posedge clk_sys);
        bus_req_n <= 1'b0;
        probe_u.send_byte(8'($urandom), 1'b0);
        check("grant_busy", grant_n, 1'b1);
        probe_u.send_byte(8'($urandom), 1'b1);
        // Only the block's own status is read while the bus is granted
        repeat (8) @(posedge clk_sys);
        check("grant_done", grant_n, 1'b0);
        ahb(1'b0, 32'(debug_serial_port_pkg::OFS_STAT), 32'h0, r);
        check("stat", r, 32'h0000_0005);
        complete_run();
    end
endmodule
